/* src/fsr_bank.sv */
// Fault status and soft reset register bank.
// Assumes a byte-wide control port and synchronous fault levels.
`include "fsr_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module fsr_bank #(
	parameter int SOFT_RESET_CYCLES = `FSR_SOFT_RESET_CYCLES
) (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ce,
	// Control port
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	output logic             reg_err,
	// Thermal sources
	input  wire logic        die_above_shutdown,
	input  wire logic        die_above_warn_one,
	input  wire logic        die_above_warn_two,
	input  wire logic        foldback_active,
	// Other fault sources
	input  wire logic        otp_load_failed,
	input  wire logic        speaker_overcurrent,
	input  wire logic        internal_speaker_monitor_error,
	input  wire logic        internal_clock_error,
	input  wire logic        external_clock_recovered,
	input  wire logic        external_clock_error,
	input  wire logic        external_data_error,
	// Device reset request
	output logic             soft_reset
);

	// ==========================================
	// Elaboration check
	if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 255) begin : g_bad_cycles
		$error("fsr_bank: SOFT_RESET_CYCLES must be 1 to 255");
	end

	localparam logic [7:0] HOLD_LAST = 8'(SOFT_RESET_CYCLES - 1);

	// ==========================================
	// Address decode
	function automatic logic [2:0] fsr_decode(input logic [15:0] addr);
		fsr_decode = 3'h0;
		case (addr)
			`FSR_OFS_RESET_TRIGGER: fsr_decode = 3'h1;
			`FSR_OFS_RAW_ONE:       fsr_decode = 3'h2;
			`FSR_OFS_RAW_TWO:       fsr_decode = 3'h4;
			default:                fsr_decode = 3'h0;
		endcase
	endfunction

	logic [2:0] sel;
	logic       trigger_write;

	always_comb begin
		sel = fsr_decode(reg_addr);
		trigger_write = reg_wr && sel[0] && reg_wdata[`FSR_BIT_SOFT_RESET];
	end

	// ==========================================
	// Soft reset sequencer
	fsr_pkg::fsr_state_t state;
	fsr_pkg::fsr_state_t next_state;
	logic [7:0]          hold_cnt;
	logic [7:0]          next_hold_cnt;
	logic                next_soft_reset;
	logic                bank_clear;

	always_comb begin
		next_state      = state;
		next_hold_cnt   = hold_cnt;
		next_soft_reset = 1'b0;
		case (state)
			fsr_pkg::FSR_ST_RUN: begin
				if (trigger_write) begin
					next_state      = fsr_pkg::FSR_ST_HOLD;
					next_hold_cnt   = 8'h00;
					next_soft_reset = 1'b1;
				end
			end
			fsr_pkg::FSR_ST_HOLD: begin
				if (hold_cnt == HOLD_LAST) begin
					next_state = fsr_pkg::FSR_ST_RUN;
				end else begin
					next_hold_cnt   = hold_cnt + 8'h01;
					next_soft_reset = 1'b1;
				end
			end
			default: begin
				next_state = fsr_pkg::FSR_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state      <= fsr_pkg::FSR_ST_RUN;
			hold_cnt   <= 8'h00;
			soft_reset <= 1'b0;
		end else if (ce) begin
			state      <= next_state;
			hold_cnt   <= next_hold_cnt;
			soft_reset <= next_soft_reset;
		end
	end

	assign bank_clear = trigger_write || (state == fsr_pkg::FSR_ST_HOLD);

	// ==========================================
	// Thermal episodes
	logic [3:0] ep_level;
	logic [3:0] ep_begin;
	logic [3:0] ep_end;

	assign ep_level[fsr_pkg::FSR_EP_SHDN]  = die_above_shutdown;
	assign ep_level[fsr_pkg::FSR_EP_WARN1] = die_above_warn_one;
	assign ep_level[fsr_pkg::FSR_EP_WARN2] = die_above_warn_two;
	assign ep_level[fsr_pkg::FSR_EP_FB]    = foldback_active;

	fsr_episode_tracker #(
		.N (4)
	) u_episodes (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.ce         (ce),
		.clear      (bank_clear),
		.level      (ep_level),
		.begin_flag (ep_begin),
		.end_flag   (ep_end)
	);

	// ==========================================
	// Level fault flags
	logic otp_load_fail_flag;
	logic speaker_overcurrent_flag;
	logic internal_speaker_monitor_error_flag;
	logic internal_clock_error_flag;
	logic external_clock_recover_flag;
	logic external_clock_error_flag;
	logic external_data_error_flag;
	logic [6:0] lvl_q;
	logic [6:0] next_lvl_q;

	always_comb begin
		if (bank_clear) begin
			next_lvl_q = 7'h00;
		end else begin
			next_lvl_q = {otp_load_failed, speaker_overcurrent,
				internal_speaker_monitor_error, internal_clock_error,
				external_clock_recovered, external_clock_error,
				external_data_error};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lvl_q <= 7'h00;
		end else if (ce) begin
			lvl_q <= next_lvl_q;
		end
	end

	assign otp_load_fail_flag                  = lvl_q[6];
	assign speaker_overcurrent_flag            = lvl_q[5];
	assign internal_speaker_monitor_error_flag = lvl_q[4];
	assign internal_clock_error_flag           = lvl_q[3];
	assign external_clock_recover_flag         = lvl_q[2];
	assign external_clock_error_flag           = lvl_q[1];
	assign external_data_error_flag            = lvl_q[0];

	// ==========================================
	// Raw status assembly
	logic [7:0] raw_one;
	logic [7:0] raw_two;

	always_comb begin
		raw_one = `FSR_RST_RAW_ONE;
		raw_one[`FSR_BIT_SHDN_BEGIN]  = ep_begin[fsr_pkg::FSR_EP_SHDN];
		raw_one[`FSR_BIT_SHDN_END]    = ep_end[fsr_pkg::FSR_EP_SHDN];
		raw_one[`FSR_BIT_WARN1_BEGIN] = ep_begin[fsr_pkg::FSR_EP_WARN1];
		raw_one[`FSR_BIT_WARN1_END]   = ep_end[fsr_pkg::FSR_EP_WARN1];
		raw_one[`FSR_BIT_FB_BEGIN]    = ep_begin[fsr_pkg::FSR_EP_FB];
		raw_one[`FSR_BIT_FB_END]      = ep_end[fsr_pkg::FSR_EP_FB];
		raw_one[`FSR_BIT_OTP_FAIL]    = otp_load_fail_flag;
		raw_one[`FSR_BIT_SPK_OVC]     = speaker_overcurrent_flag;
		raw_two = `FSR_RST_RAW_TWO;
		raw_two[`FSR_BIT_WARN2_BEGIN] = ep_begin[fsr_pkg::FSR_EP_WARN2];
		raw_two[`FSR_BIT_WARN2_END]   = ep_end[fsr_pkg::FSR_EP_WARN2];
		raw_two[`FSR_BIT_SPKMON_ERR]  = internal_speaker_monitor_error_flag;
		raw_two[`FSR_BIT_INT_CLK_ERR] = internal_clock_error_flag;
		raw_two[`FSR_BIT_RESERVED]    = 1'b0;
		raw_two[`FSR_BIT_CLK_RECOVER] = external_clock_recover_flag;
		raw_two[`FSR_BIT_CLK_ERR]     = external_clock_error_flag;
		raw_two[`FSR_BIT_DATA_ERR]    = external_data_error_flag;
	end

	// ==========================================
	// Read and error answers
	logic [7:0] next_reg_rdata;
	logic       next_reg_rvalid;
	logic       next_reg_err;

	always_comb begin
		next_reg_rdata  = 8'h00;
		next_reg_rvalid = 1'b0;
		next_reg_err    = 1'b0;
		if (reg_rd) begin
			next_reg_rvalid = 1'b1;
			case (sel)
				3'h1:    next_reg_rdata = `FSR_RST_RESET_TRIGGER;
				3'h2:    next_reg_rdata = raw_one;
				3'h4:    next_reg_rdata = raw_two;
				default: next_reg_err   = 1'b1;
			endcase
		end
		if (reg_wr && (sel == 3'h0)) begin
			next_reg_err = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
			reg_err    <= 1'b0;
		end else if (ce) begin
			reg_rdata  <= next_reg_rdata;
			reg_rvalid <= next_reg_rvalid;
			reg_err    <= next_reg_err;
		end
	end

endmodule

`default_nettype wire

/* src/fsr_consts.svh */
// Constants of the fault status and soft reset bank.
// Assumes byte-wide registers on a 16-bit control address.
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

// ==========================================
// Register offsets
`define FSR_OFS_RESET_TRIGGER 16'h2000
`define FSR_OFS_RAW_ONE       16'h2001
`define FSR_OFS_RAW_TWO       16'h2002

// ==========================================
// Reset values
`define FSR_RST_RESET_TRIGGER 8'h00
`define FSR_RST_RAW_ONE       8'h00
`define FSR_RST_RAW_TWO       8'h00

// ==========================================
// Reset trigger field
`define FSR_BIT_SOFT_RESET 0

// ==========================================
// Raw status one fields
`define FSR_BIT_SHDN_BEGIN  7
`define FSR_BIT_SHDN_END    6
`define FSR_BIT_WARN1_BEGIN 5
`define FSR_BIT_WARN1_END   4
`define FSR_BIT_FB_BEGIN    3
`define FSR_BIT_FB_END      2
`define FSR_BIT_OTP_FAIL    1
`define FSR_BIT_SPK_OVC     0

// ==========================================
// Raw status two fields
`define FSR_BIT_WARN2_BEGIN 7
`define FSR_BIT_WARN2_END   6
`define FSR_BIT_SPKMON_ERR  5
`define FSR_BIT_INT_CLK_ERR 4
`define FSR_BIT_RESERVED    3
`define FSR_BIT_CLK_RECOVER 2
`define FSR_BIT_CLK_ERR     1
`define FSR_BIT_DATA_ERR    0

// ==========================================
// Timing
`define FSR_SOFT_RESET_CYCLES 4

`endif

/* src/fsr_episode_tracker.sv */
// Begin and end indicators for level conditions.
// Assumes levels synchronous to clk; clear is synchronous.
`timescale 1ns/10ps
`default_nettype none

module fsr_episode_tracker #(
	parameter int N = 4
) (
	// Clock and control
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	input  wire logic         clear,
	// Condition levels
	input  wire logic [N-1:0] level,
	// Indicators
	output logic      [N-1:0] begin_flag,
	output logic      [N-1:0] end_flag
);

	// ==========================================
	// Elaboration check
	if (N < 1) begin : g_bad_n
		$error("fsr_episode_tracker: N must be at least 1");
	end

	// ==========================================
	// Episode state
	logic [N-1:0] seen_above;
	logic [N-1:0] next_seen_above;
	logic [N-1:0] next_begin_flag;
	logic [N-1:0] next_end_flag;

	always_comb begin
		next_seen_above = seen_above;
		next_begin_flag = begin_flag;
		next_end_flag   = end_flag;
		if (clear) begin
			next_seen_above = '0;
			next_begin_flag = '0;
			next_end_flag   = '0;
		end else begin
			next_seen_above = seen_above | level;
			next_begin_flag = level;
			next_end_flag   = seen_above & ~level;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			seen_above <= '0;
			begin_flag <= '0;
			end_flag   <= '0;
		end else if (ce) begin
			seen_above <= next_seen_above;
			begin_flag <= next_begin_flag;
			end_flag   <= next_end_flag;
		end
	end

endmodule

`default_nettype wire

/* src/fsr_pkg.sv */
// Types of the fault status and soft reset bank.
// Assumes nothing of its surroundings.
package fsr_pkg;

	// ==========================================
	// Soft reset sequencer states
	typedef enum logic [1:0] {
		FSR_ST_RUN  = 2'b01,
		FSR_ST_HOLD = 2'b10
	} fsr_state_t;

	// ==========================================
	// Indices into the episode tracker
	typedef enum int {
		FSR_EP_SHDN  = 0,
		FSR_EP_WARN1 = 1,
		FSR_EP_WARN2 = 2,
		FSR_EP_FB    = 3
	} fsr_episode_t;

endpackage

/* test/fsr_bank_bench.sv */
// Testbench of the fault status and soft reset bank.
// Assumes the checker is bound; ce drops only in the enable test.
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module fsr_bank_bench;
	localparam int RST_CYC = 4;
	logic        clk;
	logic        sys_rst;
	logic        ce;
	logic [15:0] reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	logic        reg_err;
	logic        soft_reset;
	logic [10:0] src;
	int          n_errors;
	int          cmp_count;
	int          n;

	fsr_bank #(.SOFT_RESET_CYCLES(RST_CYC)) u_dut (
		.clk, .sys_rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .reg_err,
		.die_above_shutdown(src[10]), .die_above_warn_one(src[9]), .die_above_warn_two(src[8]),
		.foldback_active(src[7]), .otp_load_failed(src[6]), .speaker_overcurrent(src[5]),
		.internal_speaker_monitor_error(src[4]), .internal_clock_error(src[3]),
		.external_clock_recovered(src[2]), .external_clock_error(src[1]),
		.external_data_error(src[0]), .soft_reset
	);

	// ==========================================
	// Clock and access tasks
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_err, a > 16'h2002)
		if (a <= 16'h2002)
			`CHK(reg_rdata, exp)
	endtask

	task automatic final_report;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================
	// Tests
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		src = 11'h000;
		n_errors = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk);
		#1 sys_rst = 1'b0;
		rd_chk(16'h2000, 8'h00);
		rd_chk(16'h2001, 8'h00);
		rd_chk(16'h2002, 8'h00);
		rd_chk(16'h2003, 8'h00);
		$display("test reset values done");
		src = 11'h7ff;
		rd_chk(16'h2001, 8'hab);
		rd_chk(16'h2002, 8'hb7);
		wr(16'h2001, 8'h00);
		wr(16'h2002, 8'hff);
		rd_chk(16'h2001, 8'hab);
		rd_chk(16'h2002, 8'hb7);
		src = 11'h000;
		rd_chk(16'h2001, 8'h54);
		rd_chk(16'h2002, 8'h40);
		src = 11'h400;
		rd_chk(16'h2001, 8'h94);
		for (int i = 0; i < 7; i++) begin
			src = {4'h8, 7'h01 << i};
			rd_chk(16'h2001, 8'h94 | {6'h00, src[6:5]});
			rd_chk(16'h2002, 8'h40 | {2'b00, src[4:3], 1'b0, src[2:0]});
		end
		$display("test status bits done");
		src = 11'h400;
		wr(16'h2004, 8'h01);
		`CHK(reg_err, 1'b1)
		@(posedge clk);
		#1 ce = 1'b0;
		wr(16'h2000, 8'h01);
		@(posedge clk);
		#1 reg_rd = 1'b1;
		reg_addr = 16'h2001;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		ce = 1'b1;
		`CHK(soft_reset, 1'b0)
		`CHK(reg_rvalid, 1'b0)
		$display("test enable and unmapped done");
		wr(16'h2000, 8'hfe);
		repeat (6) begin
			@(posedge clk);
			#1 `CHK(soft_reset, 1'b0)
		end
		rd_chk(16'h2001, 8'h94);
		wr(16'h2000, 8'h01);
		`CHK(soft_reset, 1'b1)
		rd_chk(16'h2001, 8'h00);
		rd_chk(16'h2000, 8'h00);
		n = 0;
		while (soft_reset === 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 20) begin
			n_errors++;
		end else begin
			repeat (2) @(posedge clk);
			rd_chk(16'h2001, 8'h80);
			rd_chk(16'h2002, 8'h00);
		end
		$display("test soft reset done");
		final_report();
	end
endmodule

`default_nettype wire

/* test/fsr_bank_sva.sv */
// Checker of the fault status and soft reset bank.
// Assumes requests count only with ce high; bound to every fsr_bank.
`timescale 1ns/10ps
`default_nettype none

module fsr_bank_sva #(
	parameter int SOFT_RESET_CYCLES = 4
) (
	// Clock, reset and enable
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        ce,
	// Control port
	input wire logic [15:0] reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        reg_err,
	// Sources and reset request
	input wire logic        die_above_shutdown,
	input wire logic        external_data_error,
	input wire logic        soft_reset
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ==========================================
	// Length of the reset request
	logic [7:0] run_len;
	logic [7:0] next_run_len;
	always_comb begin
		next_run_len = soft_reset ? run_len + 8'h01 : 8'h00;
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			run_len <= 8'h00;
		else
			run_len <= next_run_len;
	end

	// ==========================================
	// Properties
	property p_rd_answer;
		ce && reg_rd |=> reg_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_trig_start;
		ce && reg_wr && reg_addr == 16'h2000 && reg_wdata[0] && !soft_reset |=> soft_reset;
	endproperty
	a_trig_start: assert property (p_trig_start) else $error("reset request not raised");
	property p_len;
		$fell(soft_reset) |-> run_len == 8'(SOFT_RESET_CYCLES);
	endproperty
	a_len: assert property (p_len) else $error("reset request length wrong");
	property p_zero_write;
		ce && reg_wr && reg_addr == 16'h2000 && !reg_wdata[0] && !soft_reset |=> !soft_reset;
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write acted");
	property p_trig_read_zero;
		ce && reg_rd && reg_addr == 16'h2000 |=> reg_rdata == 8'h00;
	endproperty
	a_trig_read_zero: assert property (p_trig_read_zero) else $error("trigger read not zero");
	property p_shdn_follow;
		ce && reg_rd && reg_addr == 16'h2001 && !soft_reset && !$past(soft_reset) && !$past(sys_rst)
			&& !$past(sys_rst, 2) |=> reg_rdata[7] == $past(die_above_shutdown, 2);
	endproperty
	a_shdn_follow: assert property (p_shdn_follow) else $error("shutdown bit wrong");
	property p_data_follow;
		ce && reg_rd && reg_addr == 16'h2002 && !soft_reset && !$past(soft_reset) && !$past(sys_rst)
			&& !$past(sys_rst, 2) |=> reg_rdata[0] == $past(external_data_error, 2);
	endproperty
	a_data_follow: assert property (p_data_follow) else $error("data error bit wrong");
	property p_reserved;
		ce && reg_rd && reg_addr == 16'h2002 |=> !reg_rdata[3];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");
	property p_raw_cleared;
		ce && reg_rd && soft_reset && (reg_addr == 16'h2001 || reg_addr == 16'h2002) |=> reg_rdata == 8'h00;
	endproperty
	a_raw_cleared: assert property (p_raw_cleared) else $error("raw not cleared in reset");
	property p_unmapped;
		ce && (reg_rd || reg_wr) && !(reg_addr inside {16'h2000, 16'h2001, 16'h2002}) |=> reg_err;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
	property p_freeze;
		!ce |=> $stable(reg_rvalid) && $stable(reg_rdata) && $stable(soft_reset);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");

	c_soft_reset: cover property ($rose(soft_reset));
	c_unmapped: cover property (reg_err);
	c_shdn_read: cover property (reg_rvalid && reg_rdata[7]);
endmodule

bind fsr_bank fsr_bank_sva #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_sva (
	.clk, .sys_rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
	.reg_err, .die_above_shutdown, .external_data_error, .soft_reset
);

`default_nettype wire
